// [dv/rcsu_checker.sv]
// Port checker for the reset and clock select unit.
// Assumes binding into rcsu_top; one clock domain, presetn as its reset.
`timescale 1ns/1ps
module rcsu_checker
  import rcsu_pkg::*;
#(
  parameter int MS_CYCLES = RCSU_MS_CYCLES
)
(
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [rcsu_pkg::RCSU_ADDR_W-1:0] paddr,
  input wire logic [rcsu_pkg::RCSU_DATA_W-1:0] prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire logic                          reset_pin_n,
  input wire logic                          wdt_reset_req,
  input wire logic                          chip_reset_n,
  input wire logic                          init_stage,
  input wire rcsu_pkg::rcsu_clk_src_t       clk_src_sel,
  input wire logic                          one_clock_mode,
  input wire logic                          xtal1_gpio_en,
  input wire logic                          crystal_output_pin_gpio_en
);
  logic [31:0] low_cnt_q;
  logic        map_s;
  logic        acc_s;

  assign map_s = paddr inside {RCSU_ADR_IFCTRL, RCSU_ADR_CAUSE, RCSU_ADR_SWRST, RCSU_ADR_KEY};
  assign acc_s = psel && penable;

  // Length of the current chip reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
    end else if (chip_reset_n) begin
      low_cnt_q <= '0;
    end else begin
      low_cnt_q <= low_cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (acc_s |-> pready) else $error("access without ready");
  a_unmapped_err: assert property (acc_s && !map_s |-> pslverr) else $error("no error on hole");
  a_mapped_ok: assert property (acc_s && map_s |-> !pslverr) else $error("error on register");
  a_cause_unused: assert property (acc_s && !pwrite && paddr == RCSU_ADR_CAUSE
    |-> prdata[31:5] == 27'h0) else $error("cause upper bits set");
  a_init_once: assert property (init_stage |=> !init_stage && chip_reset_n)
    else $error("init stage not one cycle");
  a_boot_clock: assert property (!chip_reset_n |-> clk_src_sel == RCSU_CS_INT_DIV1)
    else $error("boot clock not internal");
  a_wdt_reset: assert property (wdt_reset_req |-> ##[1:3] !chip_reset_n)
    else $error("watchdog did not reset");
  a_pin_reset: assert property (!reset_pin_n [*3] |-> ##[0:3] !chip_reset_n)
    else $error("pin did not reset");
  a_min_length: assert property ($rose(chip_reset_n)
    |-> low_cnt_q >= RCSU_T_4MS * MS_CYCLES - 2) else $error("reset too short");
  // Pin reassignment follows the source latched at init, not the live config
  a_x1_gpio: assert property (xtal1_gpio_en |-> chip_reset_n
    && !(clk_src_sel inside {RCSU_CS_XTAL, RCSU_CS_EXT_OSC})) else $error("xtal1 gpio wrong");
  a_x2_gpio: assert property (crystal_output_pin_gpio_en |-> chip_reset_n
    && clk_src_sel != RCSU_CS_XTAL) else $error("crystal_output_pin gpio wrong");
  a_two_clock: assert property (!chip_reset_n ##1 !chip_reset_n |-> !one_clock_mode)
    else $error("one clock mode in reset");

  c_run: cover property ($rose(chip_reset_n));
  c_one_clk: cover property ($rose(one_clock_mode));
  c_hole: cover property (acc_s && pslverr);
endmodule

bind rcsu_top rcsu_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req),
  .chip_reset_n(chip_reset_n), .init_stage(init_stage), .clk_src_sel(clk_src_sel),
  .one_clock_mode(one_clock_mode), .xtal1_gpio_en(xtal1_gpio_en),
  .crystal_output_pin_gpio_en(crystal_output_pin_gpio_en));

// [dv/rcsu_top_bench.sv]
// Self-checking bench for the reset and clock select unit.
// Assumes a shortened millisecond of MS cycles and a zero-wait APB slave.
`timescale 1ns/1ps
module rcsu_top_bench;
  import rcsu_pkg::*;
  localparam int MS = 10;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          reset_pin_n, wdt_reset_req, brownout_det, cfg_xtal1_gpio, cfg_crystal_output_pin_gpio;
  logic [2:0]    cfg_rst_time, cfg_clk_src;
  logic          chip_reset_n, init_stage, one_clock_mode, xtal1_gpio_en, crystal_output_pin_gpio_en;
  rcsu_clk_src_t clk_src_sel;
  logic [7:0]    exp_cause;
  int            error_cnt, tests_run, n, lo;
  int            ms_tab[8] = '{25, 200, 100, 50, 16, 8, 4, 25};
  logic [7:0]    bit_tab[4] = '{8'h04, 8'h08, 8'h02, 8'h10};

  rcsu_top #(.MS_CYCLES(MS)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .wdt_reset_req(wdt_reset_req), .brownout_det(brownout_det),
    .cfg_rst_time(cfg_rst_time), .cfg_clk_src(cfg_clk_src), .cfg_xtal1_gpio(cfg_xtal1_gpio),
    .cfg_crystal_output_pin_gpio(cfg_crystal_output_pin_gpio), .chip_reset_n(chip_reset_n), .init_stage(init_stage),
    .clk_src_sel(clk_src_sel), .one_clock_mode(one_clock_mode),
    .xtal1_gpio_en(xtal1_gpio_en), .crystal_output_pin_gpio_en(crystal_output_pin_gpio_en));

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Unused source code falls back to the undivided internal oscillator
  function automatic logic [31:0] exp_src(input logic [2:0] c);
    return (c > RCSU_CS_INT_DIV16) ? 32'h0 : {29'h0, c};
  endfunction

  function automatic logic exp_x1(input logic [2:0] c, input logic req);
    return req && c != RCSU_CS_XTAL && c != RCSU_CS_EXT_OSC;
  endfunction

  function automatic logic exp_x2(input logic [2:0] c, input logic req);
    return req && c != RCSU_CS_XTAL;
  endfunction

  function automatic logic len_ok(input int got, input int ms);
    return got >= ms * MS - 1 && got <= ms * MS + 12;
  endfunction

  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      chk("apb answer", 1, 0);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, {24'h0, e}, rd);
  endtask

  task automatic unlock(input logic [7:0] mid);
    apb(1'b1, RCSU_ADR_KEY, 32'h55);
    apb(1'b1, RCSU_ADR_KEY, {24'h0, mid});
    apb(1'b1, RCSU_ADR_KEY, 32'h5a);
  endtask

  // Cycles until the chip leaves reset, bounded
  task automatic wait_run();
    lo = 0;
    while (chip_reset_n !== 1'b1 && lo < 3000) begin
      // Sampled away from the edge that launches it
      @(negedge pclk);
      lo++;
    end
    if (lo >= 3000) begin
      chk("leave reset", 1, 0);
      end_sim();
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, wdt_reset_req, brownout_det} = '0;
    {paddr, pwdata, cfg_rst_time, cfg_clk_src, cfg_xtal1_gpio, cfg_crystal_output_pin_gpio} = '0;
    reset_pin_n = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    n = $urandom(32'hfe9f);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    chk("por length", 1, len_ok(lo, RCSU_T_25MS));
    rdchk("cause after por", RCSU_ADR_CAUSE, 8'h01);
    rdchk("ifctrl reset", RCSU_ADR_IFCTRL, 8'h00);
    rdchk("swrst reset", RCSU_ADR_SWRST, 8'h00);
    rdchk("key reset", RCSU_ADR_KEY, 8'h00);
    apb(1'b0, 12'h000, 32'h0);
    chk("hole error", 1, er);
    chk("hole data", 0, rd);
    apb(1'b1, RCSU_ADR_CAUSE, 32'hff);
    rdchk("cause write ones", RCSU_ADR_CAUSE, 8'h01);
    apb(1'b1, RCSU_ADR_CAUSE, 32'h00);
    rdchk("cause cleared", RCSU_ADR_CAUSE, 8'h00);
    apb(1'b1, RCSU_ADR_SWRST, 32'hff);
    rdchk("locked swrst", RCSU_ADR_SWRST, 8'h00);
    rdchk("locked no reset", RCSU_ADR_CAUSE, 8'h00);
    unlock(8'haa);
    apb(1'b1, RCSU_ADR_SWRST, 32'hfe);
    rdchk("swrst fe", RCSU_ADR_SWRST, 8'h00);
    apb(1'b1, RCSU_ADR_SWRST, 32'hff);
    rdchk("grant dropped", RCSU_ADR_CAUSE, 8'h00);
    unlock(8'h00);
    apb(1'b1, RCSU_ADR_SWRST, 32'hff);
    rdchk("broken key", RCSU_ADR_CAUSE, 8'h00);
    exp_cause = 8'h00;
    for (int i = 0; i < 8; i++) begin
      cfg_rst_time <= i[2:0];
      // Crystal, external oscillator and the unused code are forced once each
      cfg_clk_src <= (i < 2) ? 3'(i + 1) : (i == 7) ? 3'h7 : 3'($urandom_range(7));
      cfg_xtal1_gpio <= (i < 2) || 1'($urandom);
      cfg_crystal_output_pin_gpio <= (i < 2) || 1'($urandom);
      apb(1'b1, RCSU_ADR_IFCTRL, 32'h80);
      @(negedge pclk);
      chk("one clock on", 1, one_clock_mode);
      if (i % 4 == 0) begin
        unlock(8'haa);
        apb(1'b1, RCSU_ADR_SWRST, 32'hff);
      end else begin
        @(posedge pclk);
        wdt_reset_req <= (i % 4 == 1);
        brownout_det <= (i % 4 == 2);
        reset_pin_n <= (i % 4 != 3);
        repeat ((i % 4 == 1) ? 1 : 4) @(posedge pclk);
        {wdt_reset_req, brownout_det, reset_pin_n} <= 3'b001;
      end
      repeat (4) @(posedge pclk);
      chk("reset entered", 0, chip_reset_n);
      chk("boot clock", 0, 32'(clk_src_sel));
      wait_run();
      chk("reset length", 1, len_ok(lo + 4, ms_tab[i]));
      @(negedge pclk);
      exp_cause = exp_cause | bit_tab[i % 4];
      chk("clock source", exp_src(cfg_clk_src), 32'(clk_src_sel));
      chk("two clock after reset", 0, one_clock_mode);
      chk("crystal_output_pin gpio", exp_x2(cfg_clk_src, cfg_crystal_output_pin_gpio), crystal_output_pin_gpio_en);
      chk("xtal1 gpio", exp_x1(cfg_clk_src, cfg_xtal1_gpio), xtal1_gpio_en);
      rdchk("cause sticky", RCSU_ADR_CAUSE, exp_cause);
      rdchk("swrst self clear", RCSU_ADR_SWRST, 8'h00);
    end
    apb(1'b1, RCSU_ADR_CAUSE, {24'h0, exp_cause & 8'hfb});
    rdchk("clear soft flag", RCSU_ADR_CAUSE, exp_cause & 8'hfb);
    end_sim();
  end
endmodule

// [logic/rcsu_key_unlock.sv]
// Access key sequence detector granting soft reset write permission.
// Assumes key writes arrive as one-cycle pulses from the register slave.
`timescale 1ns/1ps
module rcsu_key_unlock
  import rcsu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  rcsu_sub_if.key   sub
);
  logic [1:0] stage_q;
  logic       granted_q;

  assign sub.granted = granted_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_q   <= 2'h0;
      granted_q <= 1'b0;
    end else if (sub.key_clr) begin
      stage_q   <= 2'h0;
      granted_q <= 1'b0;
    end else if (sub.key_wr) begin
      granted_q <= 1'b0;
      if (stage_q == 2'h1 && sub.key_data == RCSU_KEY2) begin
        stage_q <= 2'h2;
      end else if (stage_q == 2'h2 && sub.key_data == RCSU_KEY3) begin
        stage_q   <= 2'h0;
        granted_q <= 1'b1;
      end else if (sub.key_data == RCSU_KEY1) begin
        stage_q <= 2'h1;
      end else begin
        stage_q <= 2'h0;
      end
    end
  end
endmodule

// [logic/rcsu_pkg.sv]
// Constants and types of the reset and clock select unit.
// Assumes an APB slave on pclk; byte address is four times the register index.
package rcsu_pkg;
  localparam int          RCSU_ADDR_W      = 12;
  localparam int          RCSU_DATA_W      = 32;
  localparam int          RCSU_CNT_W       = 32;
  localparam logic [7:0]  RCSU_IDX_IFCTRL  = 8'h8f;
  localparam logic [7:0]  RCSU_IDX_CAUSE   = 8'ha1;
  localparam logic [7:0]  RCSU_IDX_SWRST   = 8'he7;
  localparam logic [7:0]  RCSU_IDX_KEY     = 8'hf7;
  localparam logic [11:0] RCSU_ADR_IFCTRL  = {2'h0, RCSU_IDX_IFCTRL, 2'h0};
  localparam logic [11:0] RCSU_ADR_CAUSE   = {2'h0, RCSU_IDX_CAUSE, 2'h0};
  localparam logic [11:0] RCSU_ADR_SWRST   = {2'h0, RCSU_IDX_SWRST, 2'h0};
  localparam logic [11:0] RCSU_ADR_KEY     = {2'h0, RCSU_IDX_KEY, 2'h0};
  localparam int          RCSU_ONE_CLK_BIT = 7;
  localparam int          RCSU_PIN_BIT     = 4;
  localparam int          RCSU_WDT_BIT     = 3;
  localparam int          RCSU_SW_BIT      = 2;
  localparam int          RCSU_BOR_BIT     = 1;
  localparam int          RCSU_POR_BIT     = 0;
  localparam logic [7:0]  RCSU_FLAG_MASK   = 8'h1f;
  localparam logic [7:0]  RCSU_REG_RST     = 8'h00;
  localparam logic [7:0]  RCSU_KEY1        = 8'h55;
  localparam logic [7:0]  RCSU_KEY2        = 8'haa;
  localparam logic [7:0]  RCSU_KEY3        = 8'h5a;
  localparam logic [7:0]  RCSU_SW_TRIG     = 8'hff;
  localparam int          RCSU_CLK_HZ      = 250_000_000;
  localparam int          RCSU_MS_CYCLES   = RCSU_CLK_HZ / 1000;
  localparam int          RCSU_T_25MS      = 25;
  localparam int          RCSU_T_200MS     = 200;
  localparam int          RCSU_T_100MS     = 100;
  localparam int          RCSU_T_50MS      = 50;
  localparam int          RCSU_T_16MS      = 16;
  localparam int          RCSU_T_8MS       = 8;
  localparam int          RCSU_T_4MS       = 4;

  typedef enum logic [2:0] {
    RCSU_RT_25 = 3'h0, RCSU_RT_200 = 3'h1, RCSU_RT_100 = 3'h2, RCSU_RT_50 = 3'h3,
    RCSU_RT_16 = 3'h4, RCSU_RT_8 = 3'h5, RCSU_RT_4 = 3'h6
  } rcsu_rst_time_t;

  typedef enum logic [2:0] {
    RCSU_CS_INT_DIV1 = 3'h0, RCSU_CS_XTAL = 3'h1, RCSU_CS_EXT_OSC = 3'h2,
    RCSU_CS_INT_DIV2 = 3'h3, RCSU_CS_INT_DIV4 = 3'h4, RCSU_CS_INT_DIV8 = 3'h5,
    RCSU_CS_INT_DIV16 = 3'h6
  } rcsu_clk_src_t;

  typedef enum logic [1:0] {
    RCSU_ST_HOLD = 2'b00, RCSU_ST_INIT = 2'b01, RCSU_ST_RUN = 2'b11
  } rcsu_state_t;

  // Reset length in ms for a configuration code; unknown codes use the default
  function automatic int rcsu_rst_ms(input logic [2:0] sel);
    case (sel)
      RCSU_RT_200: return RCSU_T_200MS;
      RCSU_RT_100: return RCSU_T_100MS;
      RCSU_RT_50:  return RCSU_T_50MS;
      RCSU_RT_16:  return RCSU_T_16MS;
      RCSU_RT_8:   return RCSU_T_8MS;
      RCSU_RT_4:   return RCSU_T_4MS;
      default:     return RCSU_T_25MS;
    endcase
  endfunction
endpackage

// [logic/rcsu_rst_timer.sv]
// Down counter that times the internal reset duration.
// Assumes a start pulse or level reloads it; load is never zero.
`timescale 1ns/1ps
module rcsu_rst_timer
  import rcsu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  rcsu_sub_if.tmr   sub
);
  logic [RCSU_CNT_W-1:0] cnt_q;
  logic                  busy_q;

  assign sub.tmr_busy = busy_q;
  assign sub.tmr_done = busy_q && !sub.tmr_start && cnt_q <= 32'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (sub.tmr_start) begin
      cnt_q  <= sub.tmr_load;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 32'd1;
      if (cnt_q <= 32'd1) begin
        busy_q <= 1'b0;
      end
    end
  end
endmodule

// [logic/rcsu_sub_if.sv]
// Carrier between the unit top and its key detector and reset timer.
// Assumes all users on one clock.
`timescale 1ns/1ps
interface rcsu_sub_if;
  logic        key_wr;
  logic [7:0]  key_data;
  logic        key_clr;
  logic        granted;
  logic        tmr_start;
  logic [31:0] tmr_load;
  logic        tmr_done;
  logic        tmr_busy;
  modport top (output key_wr, key_data, key_clr, tmr_start, tmr_load,
               input granted, tmr_done, tmr_busy);
  modport key (input key_wr, key_data, key_clr, output granted);
  modport tmr (input tmr_start, tmr_load, output tmr_done, tmr_busy);
endinterface

// [logic/rcsu_top.sv]
// Reset and clock select unit: reset sequencing, cause flags, soft reset,
// machine cycle mode and clock source choice, with an APB register slave.
// Assumes presetn is the always-on power-on reset; config inputs are static.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module rcsu_top
  import rcsu_pkg::*;
#(
  parameter int MS_CYCLES = RCSU_MS_CYCLES
)
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [rcsu_pkg::RCSU_ADDR_W-1:0]    paddr,
  input  wire logic [rcsu_pkg::RCSU_DATA_W-1:0]    pwdata,
  output      logic [rcsu_pkg::RCSU_DATA_W-1:0]    prdata,
  output      logic                                pready,
  output      logic                                pslverr,
  input  wire logic                                reset_pin_n,
  input  wire logic                                wdt_reset_req,
  input  wire logic                                brownout_det,
  input  wire logic [2:0]                          cfg_rst_time,
  input  wire logic [2:0]                          cfg_clk_src,
  input  wire logic                                cfg_xtal1_gpio,
  input  wire logic                                cfg_crystal_output_pin_gpio,
  output      logic                                chip_reset_n,
  output      logic                                init_stage,
  output      rcsu_pkg::rcsu_clk_src_t             clk_src_sel,
  output      logic                                one_clock_mode,
  output      logic                                xtal1_gpio_en,
  output      logic                                crystal_output_pin_gpio_en
);
  import rcsu_pkg::*;

  rcsu_sub_if sub ();

  rcsu_key_unlock u_key (
    .pclk    (pclk),
    .presetn (presetn),
    .sub     (sub.key)
  );

  rcsu_rst_timer u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .sub     (sub.tmr)
  );

  // Pin side synchronisers
  logic [1:0] pin_n_s;
  logic [1:0] bor_s;
  logic [2:0] rt_s1;
  logic [2:0] rt_s2;
  logic [2:0] cs_s1;
  logic [2:0] cs_s2;
  logic [1:0] x1_s;
  logic [1:0] x2_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_n_s <= 2'b11;
      bor_s   <= 2'b00;
      rt_s1   <= 3'h0;
      rt_s2   <= 3'h0;
      cs_s1   <= 3'h0;
      cs_s2   <= 3'h0;
      x1_s    <= 2'b00;
      x2_s    <= 2'b00;
    end else begin
      pin_n_s <= {pin_n_s[0], reset_pin_n};
      bor_s   <= {bor_s[0], brownout_det};
      rt_s1   <= cfg_rst_time;
      rt_s2   <= rt_s1;
      cs_s1   <= cfg_clk_src;
      cs_s2   <= cs_s1;
      x1_s    <= {x1_s[0], cfg_xtal1_gpio};
      x2_s    <= {x2_s[0], cfg_crystal_output_pin_gpio};
    end
  end

  // Register slave decode
  logic        acc_wr;
  logic        setup_rd;
  logic        hit;
  logic [7:0]  wbyte;
  logic        wr_ifctrl;
  logic        wr_cause;
  logic        wr_swrst;
  logic        wr_key;

  assign hit = paddr == RCSU_ADR_IFCTRL || paddr == RCSU_ADR_CAUSE ||
               paddr == RCSU_ADR_SWRST || paddr == RCSU_ADR_KEY;
  assign acc_wr    = psel && penable && pwrite;
  assign setup_rd  = psel && !penable && !pwrite;
  assign wbyte     = pwdata[7:0];
  assign wr_ifctrl = acc_wr && paddr == RCSU_ADR_IFCTRL;
  assign wr_cause  = acc_wr && paddr == RCSU_ADR_CAUSE;
  assign wr_swrst  = acc_wr && paddr == RCSU_ADR_SWRST;
  assign wr_key    = acc_wr && paddr == RCSU_ADR_KEY;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !hit;

  // Reset sources and sequencing
  rcsu_state_t state_q;
  rcsu_state_t state_d;
  logic [2:0]  por_sh_q;
  logic        por_pend;
  logic        sw_fire;
  logic        pin_rst;
  logic        bor_rst;
  logic        any_src;
  logic        in_run;

  assign in_run  = state_q == RCSU_ST_RUN;
  assign pin_rst = !pin_n_s[1];
  assign bor_rst = bor_s[1];
  assign sw_fire = wr_swrst && sub.granted && wbyte == RCSU_SW_TRIG;
  assign any_src = por_pend || pin_rst || bor_rst || wdt_reset_req || sw_fire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_sh_q <= 3'b111;
    end else begin
      por_sh_q <= {por_sh_q[1:0], 1'b0};
    end
  end

  // Power-on request outlasts the config synchroniser, so its last load sees the real code
  assign por_pend = por_sh_q[2];

  assign sub.tmr_start = any_src;
  assign sub.tmr_load  = RCSU_CNT_W'(rcsu_rst_ms(rt_s2) * MS_CYCLES);

  always_comb begin
    state_d = state_q;
    if (any_src) begin
      state_d = RCSU_ST_HOLD;
    end else begin
      unique case (state_q)
        RCSU_ST_HOLD: begin
          if (sub.tmr_done) begin
            state_d = RCSU_ST_INIT;
          end
        end
        RCSU_ST_INIT: state_d = RCSU_ST_RUN;
        RCSU_ST_RUN:  state_d = RCSU_ST_RUN;
        default:      state_d = RCSU_ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= RCSU_ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  assign chip_reset_n = in_run;
  assign init_stage   = state_q == RCSU_ST_INIT;

  // Access key register and unlock control
  logic [7:0] key_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q <= RCSU_REG_RST;
    end else if (!in_run) begin
      key_q <= RCSU_REG_RST;
    end else if (wr_key) begin
      key_q <= wbyte;
    end
  end

  assign sub.key_wr   = wr_key && in_run;
  assign sub.key_data = wbyte;
  assign sub.key_clr  = !in_run || wr_swrst;

  // Soft reset register
  logic [7:0] swrst_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swrst_q <= RCSU_REG_RST;
    end else if (sw_fire) begin
      swrst_q <= RCSU_SW_TRIG;
    end else if (sub.tmr_done) begin
      swrst_q <= RCSU_REG_RST;
    end
  end

  // Reset cause flags, set wins over a software clear
  logic [4:0] cause_q;
  logic [4:0] cause_set;
  logic [4:0] cause_keep;

  always_comb begin
    cause_set                 = 5'h00;
    cause_set[RCSU_PIN_BIT]   = pin_rst;
    cause_set[RCSU_WDT_BIT]   = wdt_reset_req;
    cause_set[RCSU_SW_BIT]    = sw_fire;
    cause_set[RCSU_BOR_BIT]   = bor_rst;
    cause_set[RCSU_POR_BIT]   = por_pend;
    cause_keep = wr_cause ? (cause_q & wbyte[4:0]) : cause_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= RCSU_REG_RST[4:0];
    end else begin
      cause_q <= cause_keep | cause_set;
    end
  end

  // Interface control, cleared by every chip reset
  logic [7:0] ifctrl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifctrl_q <= RCSU_REG_RST;
    end else if (!in_run) begin
      ifctrl_q <= RCSU_REG_RST;
    end else if (wr_ifctrl) begin
      ifctrl_q <= wbyte;
    end
  end

  assign one_clock_mode = ifctrl_q[RCSU_ONE_CLK_BIT];

  // Clock source, chosen during the init stage
  rcsu_clk_src_t src_q;
  logic          x1_gpio_q;
  logic          x2_gpio_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= RCSU_CS_INT_DIV1;
    end else if (state_q == RCSU_ST_INIT) begin
      if (cs_s2 <= RCSU_CS_INT_DIV16) begin
        src_q <= rcsu_clk_src_t'(cs_s2);
      end else begin
        src_q <= RCSU_CS_INT_DIV1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1_gpio_q <= 1'b0;
      x2_gpio_q <= 1'b0;
    end else if (state_q == RCSU_ST_INIT) begin
      unique case (cs_s2)
        RCSU_CS_XTAL: begin
          x1_gpio_q <= 1'b0;
          x2_gpio_q <= 1'b0;
        end
        RCSU_CS_EXT_OSC: begin
          x1_gpio_q <= 1'b0;
          x2_gpio_q <= x2_s[1];
        end
        default: begin
          x1_gpio_q <= x1_s[1];
          x2_gpio_q <= x2_s[1];
        end
      endcase
    end
  end

  // Internal oscillator until the chip is running
  assign clk_src_sel   = in_run ? src_q : RCSU_CS_INT_DIV1;
  assign xtal1_gpio_en = in_run && x1_gpio_q;
  assign crystal_output_pin_gpio_en = in_run && x2_gpio_q;

  // Read data captured in the setup phase
  logic [7:0] rd_byte;

  always_comb begin
    unique case (paddr)
      RCSU_ADR_IFCTRL: rd_byte = ifctrl_q;
      RCSU_ADR_CAUSE:  rd_byte = {3'h0, cause_q} & RCSU_FLAG_MASK;
      RCSU_ADR_SWRST:  rd_byte = swrst_q;
      RCSU_ADR_KEY:    rd_byte = key_q;
      default:         rd_byte = 8'h00;
    endcase
  end

  logic [RCSU_DATA_W-1:0] prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup_rd) begin
      prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign prdata = prdata_q;
endmodule
